// [flc_regs.vh]
`ifndef FLC_REGS_VH
`define FLC_REGS_VH

// Clock
`define FLC_CLK_NS          25
`define FLC_CLK_KHZ         40000

// Host command opcodes
`define FLC_OP_READ         3'h0
`define FLC_OP_PROGRAM      3'h1
`define FLC_OP_CHIP_ERASE   3'h2
`define FLC_OP_MAIN_ERASE   3'h3
`define FLC_OP_LOCKOUT      3'h4
`define FLC_OP_ID_ENTRY     3'h5
`define FLC_OP_ID_EXIT3     3'h6
`define FLC_OP_ID_EXIT1     3'h7

// Unlock addresses and command bytes
`define FLC_UNLOCK1_ADDR    16'h5555
`define FLC_UNLOCK2_ADDR    16'h2AAA
`define FLC_UNLOCK1_DATA    16'h00AA
`define FLC_UNLOCK2_DATA    16'h0055
`define FLC_CMD_SETUP       16'h0080
`define FLC_CMD_PROGRAM     16'h00A0
`define FLC_CMD_CHIP_ERASE  16'h0010
`define FLC_CMD_MAIN_ERASE  16'h0030
`define FLC_CMD_LOCKOUT     16'h0040
`define FLC_CMD_ID_ENTRY    16'h0090
`define FLC_CMD_ID_EXIT     16'h00F0

// Status bit positions
`define FLC_POLL_BIT        7
`define FLC_TOGGLE_BIT      6

// Bus timing
`define FLC_WE_LOW_NS       50
`define FLC_ACC_NS          70
`define FLC_SYNC_CYC        2
`define FLC_WE_LOW_CYC      ((`FLC_WE_LOW_NS + `FLC_CLK_NS - 1) / `FLC_CLK_NS)
`define FLC_ACC_CYC         ((`FLC_ACC_NS + `FLC_CLK_NS - 1) / `FLC_CLK_NS)
`define FLC_RD_CYC          (`FLC_ACC_CYC + `FLC_SYNC_CYC)

// Give-up time for one program or erase
`define FLC_OP_TIMEOUT_MS   20000
`define FLC_OP_TIMEOUT_CYC  (`FLC_OP_TIMEOUT_MS * `FLC_CLK_KHZ)

`endif

// [flc_host.v]
// Contract
// RQ1: Flash drives stored word when chip select and output gate low, write high.
// RQ2: Flash floats data whenever chip select or output gate is high. The model drives the inverted last read word instead.
// RQ3: Chip erase clears boot and main, or main only when locked.
// RQ4: Flash returns to array read after chip erase by itself.
// RQ5: Main erase sets non-boot words to all ones, boot kept.
// RQ6: Main erase is six writes ending 30 to 5555.
// RQ7: Erase is self-timed and needs no further strobes.
// RQ8: Programming only clears bits; only erase sets them again.
// RQ9: Word program is AA/5555, 55/2AAA, A0/5555, then data/address.
// RQ10: Address taken at later falling strobe, data at earlier rising strobe.
// RQ11: Flash times its own program pulses within word program time.
// RQ12: Boot region is words 0000 through 1FFF.
// RQ13: Lockout permanently blocks boot program and erase, main stays writable.
// RQ14: Lockout is six writes ending 40 to 5555.
// RQ15: In identification mode, word 0002 bit 0 shows lockout state.
// RQ16: Identification entry ends 90; exit by three-cycle F0 or single F0.
// RQ17: Identification codes match for software and hardware entry.
// RQ18: During program, last location reads inverted bit 7 until done.
// RQ19: During program or erase, bit 6 toggles on successive reads.
// RQ20: No program while output gate low, chip select high or write high.
// RQ21: Strobe pulses below about 15 ns start nothing.
// RQ22: Command cycles use low data byte; top address bit ignored.
// RQ23: Broken unlock sequences are discarded, decoder back to read.
// RQ24: Host waits for polling or toggle to show completion.
`timescale 1ns/1ps
`include "flc_regs.vh"
module flc_host
#(
  parameter TIMEOUT_CYC = `FLC_OP_TIMEOUT_CYC
)
(
  input  wire        core_clk_i,
  input  wire        rst_n_i,
  input  wire        cmd_valid_i,
  input  wire [2:0]  cmd_op_i,
  input  wire [15:0] cmd_addr_i,
  input  wire [15:0] cmd_data_i,
  output reg         cmd_ready_o,
  output reg         rsp_valid_o,
  output reg  [15:0] rsp_data_o,
  output reg         rsp_err_o,
  output reg         id_mode_o,
  output reg  [15:0] flash_addr_o,
  output reg  [15:0] flash_data_o,
  output reg         flash_data_oe_o,
  input  wire [15:0] flash_data_i,
  output reg         flash_ce_n_o,
  output reg         flash_oe_n_o,
  output reg         flash_we_n_o
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_WSET = 7'h02;
  localparam [6:0] S_WLOW = 7'h04;
  localparam [6:0] S_WHI  = 7'h08;
  localparam [6:0] S_GAPW = 7'h10;
  localparam [6:0] S_RD   = 7'h20;
  localparam [6:0] S_GAPR = 7'h40;
  // Write and read counts kept as integers and cut to the counter width where loaded
  localparam integer WE_LOW_CYC = `FLC_WE_LOW_CYC;
  localparam integer RD_CYC     = `FLC_RD_CYC;
  localparam [31:0]  TMO_CYC    = TIMEOUT_CYC;

  reg [6:0]  state;
  reg [2:0]  op, step;
  reg [15:0] uaddr, udata, rd;
  // Two-stage synchroniser for the data pins
  reg [15:0] sync1, sync2;
  reg [3:0]  cnt;
  reg        polling, have_prev, prev_toggle;
  reg [31:0] tmo;

  // Index of the last write cycle of each command sequence
  function [2:0] flc_last_step;
    input [2:0] fop;
    begin
      case (fop)
        `FLC_OP_PROGRAM:  flc_last_step = 3'h3;
        `FLC_OP_ID_ENTRY: flc_last_step = 3'h2;
        `FLC_OP_ID_EXIT3: flc_last_step = 3'h2;
        `FLC_OP_ID_EXIT1: flc_last_step = 3'h0;
        default:          flc_last_step = 3'h5;
      endcase
    end
  endfunction
  // Bus address of one write cycle; top address bit left low in unlock cycles
  function [15:0] flc_cyc_addr;
    input [2:0]  fop;
    input [2:0]  fstep;
    input [15:0] faddr;
    begin
      if (fop == `FLC_OP_ID_EXIT1 || (fop == `FLC_OP_PROGRAM && fstep == 3'h3))
        flc_cyc_addr = faddr;
      else if (fstep == 3'h1 || fstep == 3'h4)
        flc_cyc_addr = `FLC_UNLOCK2_ADDR;
      else
        flc_cyc_addr = `FLC_UNLOCK1_ADDR;
    end
  endfunction
  // Data of one write cycle; command bytes carry a zero upper byte
  function [15:0] flc_cyc_data;
    input [2:0]  fop;
    input [2:0]  fstep;
    input [15:0] fdata;
    begin
      case (fstep)
        3'h0: flc_cyc_data = (fop == `FLC_OP_ID_EXIT1) ? `FLC_CMD_ID_EXIT : `FLC_UNLOCK1_DATA;
        3'h1: flc_cyc_data = `FLC_UNLOCK2_DATA;
        3'h2:
          case (fop)
            `FLC_OP_PROGRAM:  flc_cyc_data = `FLC_CMD_PROGRAM;
            `FLC_OP_ID_ENTRY: flc_cyc_data = `FLC_CMD_ID_ENTRY;
            `FLC_OP_ID_EXIT3: flc_cyc_data = `FLC_CMD_ID_EXIT;
            default:          flc_cyc_data = `FLC_CMD_SETUP;
          endcase
        3'h3: flc_cyc_data = (fop == `FLC_OP_PROGRAM) ? fdata : `FLC_UNLOCK1_DATA;
        3'h4: flc_cyc_data = `FLC_UNLOCK2_DATA;
        default:
          case (fop)
            `FLC_OP_CHIP_ERASE: flc_cyc_data = `FLC_CMD_CHIP_ERASE;
            `FLC_OP_MAIN_ERASE: flc_cyc_data = `FLC_CMD_MAIN_ERASE;
            default:            flc_cyc_data = `FLC_CMD_LOCKOUT;
          endcase
      endcase
    end
  endfunction
  wire is_prog = (op == `FLC_OP_PROGRAM);
  wire needs_poll = is_prog || op == `FLC_OP_CHIP_ERASE ||
                    op == `FLC_OP_MAIN_ERASE || op == `FLC_OP_LOCKOUT;
  // Two equal toggle samples, and for a program the true bit 7, mean done
  wire poll_done = have_prev && (rd[`FLC_TOGGLE_BIT] == prev_toggle) &&
                   (!is_prog || rd[`FLC_POLL_BIT] == udata[`FLC_POLL_BIT]);
  always @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state           <= S_IDLE;
      op              <= `FLC_OP_READ;
      uaddr           <= 16'h0000;
      udata           <= 16'h0000;
      step            <= 3'h0;
      cnt             <= 4'h0;
      polling         <= 1'b0;
      have_prev       <= 1'b0;
      prev_toggle     <= 1'b0;
      tmo             <= 32'h0000_0000;
      rd              <= 16'h0000;
      sync1           <= 16'h0000;
      sync2           <= 16'h0000;
      cmd_ready_o     <= 1'b0;
      rsp_valid_o     <= 1'b0;
      rsp_data_o      <= 16'h0000;
      rsp_err_o       <= 1'b0;
      id_mode_o       <= 1'b0;
      flash_addr_o    <= 16'h0000;
      flash_data_o    <= 16'h0000;
      flash_data_oe_o <= 1'b0;
      flash_ce_n_o    <= 1'b1;
      flash_oe_n_o    <= 1'b1;
      flash_we_n_o    <= 1'b1;
    end
    else
    begin
      sync1       <= flash_data_i;
      sync2       <= sync1;
      rsp_valid_o <= 1'b0;
      if (polling)
        tmo <= tmo + 32'h0000_0001;
      case (state)
        S_IDLE:
        begin
          cmd_ready_o <= 1'b1;
          if (cmd_valid_i && cmd_ready_o)
          begin
            cmd_ready_o <= 1'b0;
            op          <= cmd_op_i;
            uaddr       <= cmd_addr_i;
            udata       <= cmd_data_i;
            step        <= 3'h0;
            polling     <= 1'b0;
            have_prev   <= 1'b0;
            tmo         <= 32'h0000_0000;
            flash_ce_n_o <= 1'b0;
            if (cmd_op_i == `FLC_OP_READ)
            begin
              flash_addr_o <= cmd_addr_i;
              flash_oe_n_o <= 1'b0; // RQ1
              cnt          <= RD_CYC[3:0];
              state        <= S_RD;
            end
            else
            begin
              // Whole sequences only, so the flash never sees a broken unlock
              flash_addr_o    <= flc_cyc_addr(cmd_op_i, 3'h0, cmd_addr_i); // RQ23
              flash_data_o    <= flc_cyc_data(cmd_op_i, 3'h0, cmd_data_i); // RQ22
              flash_data_oe_o <= 1'b1;
              state           <= S_WSET;
            end
          end
        end
        S_WSET:
        begin
          // Output gate stays high and chip select low before the strobe falls
          flash_we_n_o <= 1'b0; // RQ20
          cnt          <= WE_LOW_CYC[3:0] - 4'h1;
          state        <= S_WLOW;
        end
        S_WLOW:
        begin
          // Strobe held well past the noise filter width
          if (cnt == 4'h0)
          begin
            flash_we_n_o <= 1'b1; // RQ21
            state        <= S_WHI;
          end
          else
            cnt <= cnt - 4'h1;
        end
        S_WHI:
        begin
          // Write strobe rises first, so data is latched there with hold
          flash_ce_n_o    <= 1'b1; // RQ10
          flash_data_oe_o <= 1'b0;
          state           <= S_GAPW;
        end
        S_GAPW:
        begin
          if (step != flc_last_step(op))
          begin
            step            <= step + 3'h1;
            flash_addr_o    <= flc_cyc_addr(op, step + 3'h1, uaddr); // RQ9 RQ6 RQ14 RQ16
            flash_data_o    <= flc_cyc_data(op, step + 3'h1, udata); // RQ9 RQ6 RQ14 RQ16
            flash_data_oe_o <= 1'b1;
            flash_ce_n_o    <= 1'b0;
            state           <= S_WSET;
          end
          else if (needs_poll)
          begin
            // Program polls its own word, erases and lockout poll 5555
            polling      <= 1'b1; // RQ24
            flash_addr_o <= is_prog ? uaddr : `FLC_UNLOCK1_ADDR; // RQ18
            flash_ce_n_o <= 1'b0;
            flash_oe_n_o <= 1'b0;
            cnt          <= RD_CYC[3:0];
            state        <= S_RD;
          end
          else
          begin
            id_mode_o   <= (op == `FLC_OP_ID_ENTRY); // RQ16
            rsp_valid_o <= 1'b1;
            rsp_err_o   <= 1'b0;
            rsp_data_o  <= 16'h0000;
            cmd_ready_o <= 1'b1;
            state       <= S_IDLE;
          end
        end
        S_RD:
        begin
          // Data pins are never driven while the output gate is low
          if (cnt == 4'h0)
          begin
            rd           <= sync2; // RQ1
            flash_ce_n_o <= 1'b1;  // RQ2
            flash_oe_n_o <= 1'b1;  // RQ2
            state        <= S_GAPR;
          end
          else
            cnt <= cnt - 4'h1;
        end
        S_GAPR:
        begin
          if (!polling || poll_done || tmo >= TMO_CYC)
          begin
            // Timeout gives up rather than hanging on a dead part
            polling     <= 1'b0; // RQ19 RQ24
            rsp_valid_o <= 1'b1;
            rsp_err_o   <= polling && !poll_done;
            rsp_data_o  <= rd;
            cmd_ready_o <= 1'b1;
            state       <= S_IDLE;
          end
          else
          begin
            prev_toggle  <= rd[`FLC_TOGGLE_BIT]; // RQ19
            have_prev    <= 1'b1;
            flash_ce_n_o <= 1'b0;
            flash_oe_n_o <= 1'b0;
            cnt          <= RD_CYC[3:0];
            state        <= S_RD;
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end
endmodule

// [flc_checker.sv]
`timescale 1ns/1ps
`include "flc_regs.vh"
module flc_checker
(
  input wire        core_clk_i,
  input wire        rst_n_i,
  input wire        cmd_valid_i,
  input wire [2:0]  cmd_op_i,
  input wire        cmd_ready_o,
  input wire        rsp_valid_o,
  input wire [15:0] flash_addr_o,
  input wire [15:0] flash_data_o,
  input wire        flash_data_oe_o,
  input wire        flash_ce_n_o,
  input wire        flash_oe_n_o,
  input wire        flash_we_n_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence wr(a, d);
    $fell(flash_we_n_o) && flash_addr_o == a && flash_data_o == d;
  endsequence
  chk_no_clash:
    assert property (flash_data_oe_o |-> flash_oe_n_o) else $error("bus clash");
  chk_write_gate:
    assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o) else $error("bad write");
  chk_we_width:
    assert property ($fell(flash_we_n_o) |-> ##1 !flash_we_n_o ##1 flash_we_n_o)
    else $error("write low time");
  chk_write_hold:
    assert property ((!flash_we_n_o || $rose(flash_we_n_o)) |->
      $stable(flash_addr_o) && $stable(flash_data_o)) else $error("write hold");
  chk_unlock_pair:
    assert property (wr(16'h5555, 16'h00AA) |-> ##5 wr(16'h2AAA, 16'h0055))
    else $error("unlock pair");
  chk_setup_tail:
    assert property (wr(16'h5555, 16'h0080) |-> ##5 wr(16'h5555, 16'h00AA)
      ##5 wr(16'h2AAA, 16'h0055) ##5 ($fell(flash_we_n_o) && flash_addr_o == 16'h5555))
    else $error("setup tail");
  chk_read_pulse:
    assert property ($fell(flash_oe_n_o) |->
      (!flash_oe_n_o && !flash_ce_n_o && flash_we_n_o)[*6] ##1 flash_oe_n_o)
    else $error("read pulse");
  chk_read_time:
    assert property (cmd_valid_i && cmd_ready_o && cmd_op_i == `FLC_OP_READ |->
      ##[8:9] rsp_valid_o) else $error("read latency");
  chk_ready_drop:
    assert property (cmd_valid_i && cmd_ready_o |=> !cmd_ready_o) else $error("ready held");
endmodule
bind flc_host flc_checker chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_ready_o(cmd_ready_o),
  .rsp_valid_o(rsp_valid_o), .flash_addr_o(flash_addr_o), .flash_data_o(flash_data_o),
  .flash_data_oe_o(flash_data_oe_o), .flash_ce_n_o(flash_ce_n_o),
  .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o));

// [flc_flash_model.sv]
`timescale 1ns/1ps
module flc_flash_model
#(
  parameter PROG_NS  = 1000,
  parameter ERASE_NS = 3000,
  parameter MFR_ID   = 16'h00C3, // Arbitrary value
  parameter DEV_ID   = 16'h005A  // Arbitrary value
)
(
  input  wire        ce_n_i,
  input  wire        oe_n_i,
  input  wire        we_n_i,
  input  wire [15:0] addr_i,
  input  wire [15:0] dq_i,
  output wire [15:0] dq_o
);
  reg     [15:0] mem [0:65535];
  reg     [15:0] last, pdat, la;
  reg     [2:0]  st;
  reg            lock, idm, prg, busy, tog, u;
  time           tf;
  integer        i;
  wire           rd_en = !ce_n_i && !oe_n_i && we_n_i;
  wire    [15:0] idv = addr_i == 16'h0000 ? MFR_ID : addr_i == 16'h0001 ? DEV_ID :
                       {15'h0000, lock};
  wire    [15:0] rdat = idm ? idv : busy ? {8'h00, ~pdat[7], tog, 6'h00} : mem[addr_i];
  // No pull-up: a released bus must not look like the last word
  assign dq_o = rd_en ? rdat : ~last;
  initial
  begin
    for (i = 0; i < 65536; i = i + 1)
      mem[i] = 16'hFFFF;
    {st, lock, idm, prg, busy, tog, tf, last, pdat} = 0;
  end
  always @(posedge oe_n_i) last = rdat;
  always @(negedge oe_n_i) if (busy) tog = ~tog;
  always @(negedge we_n_i)
  begin
    la = addr_i;
    tf = $time;
  end
  task start(input integer ns);
    begin
      busy = 1;
      busy <= #(ns) 1'b0;
    end
  endtask
  task erase(input chip);
    begin
      for (i = 0; i < 65536; i = i + 1)
        if (i >= 16'h2000 || (chip && !lock)) mem[i] = 16'hFFFF;
      pdat = 16'hFFFF;
      start(ERASE_NS);
    end
  endtask
  always @(posedge we_n_i)
    if (!ce_n_i && oe_n_i && !busy && $time - tf >= 15)
    begin
      u = st == 3'd1 || st == 3'd4;
      if (prg)
      begin
        if (!(lock && la < 16'h2000)) mem[la] = mem[la] & dq_i;
        pdat = dq_i;
        prg = 0;
        start(PROG_NS);
      end
      else if (st == 3'd2 || st == 3'd5)
      begin
        u = st == 3'd5;
        st = 3'd0;
        if (la[14:0] == 15'h5555)
          case ({u, dq_i[7:0]})
            9'h0A0: prg = 1;
            9'h080: st = 3'd3;
            9'h090: idm = 1;
            9'h0F0: idm = 0;
            9'h110: erase(1);
            9'h130: erase(0);
            9'h140: lock = 1;
            default: ;
          endcase
      end
      else if (la[14:0] == (u ? 15'h2AAA : 15'h5555) && dq_i[7:0] == (u ? 8'h55 : 8'hAA))
        st = st + 3'd1;
      else
      begin
        if (st == 3'd0 && dq_i[7:0] == 8'hF0) idm = 0;
        st = 3'd0;
      end
    end
endmodule

// [flc_host_tb.sv]
`timescale 1ns/1ps
`include "flc_regs.vh"
module flc_host_tb;
  localparam MFR = 16'h00C3; // Arbitrary value
  localparam DEV = 16'h005A; // Arbitrary value
  reg     [15:0] ca, cd, a, rm [0:65535], idv [0:2];
  reg     [16:0] q [$];
  reg     [16:0] e;
  reg     [2:0]  op;
  reg            clk, rst_n, cv, lk;
  wire           rdy, rv, re, idm, doe, ce, oe, we;
  wire    [15:0] rd, fa, fo, fi, mq;
  integer        error_cnt = 0, num_checks = 0, i, k, n;
  assign fi = doe ? fo : mq;
  flc_host #(.TIMEOUT_CYC(200)) DUT (.core_clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cv),
    .cmd_op_i(op), .cmd_addr_i(ca), .cmd_data_i(cd), .cmd_ready_o(rdy), .rsp_valid_o(rv),
    .rsp_data_o(rd), .rsp_err_o(re), .id_mode_o(idm), .flash_addr_o(fa), .flash_data_o(fo),
    .flash_data_oe_o(doe), .flash_data_i(fi), .flash_ce_n_o(ce), .flash_oe_n_o(oe),
    .flash_we_n_o(we));
  flc_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) fm (.ce_n_i(ce), .oe_n_i(oe),
    .we_n_i(we), .addr_i(fa), .dq_i(fi), .dq_o(mq));
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task check(input string nm, input [16:0] s, input [16:0] x);
    begin
      num_checks++;
      if (s !== x)
      begin
        error_cnt++;
        $display("mismatch %s expected %h seen %h", nm, x, s);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(negedge clk)
    if (rv)
    begin
      if (q.size() == 0) check("queue", 0, 1);
      else
      begin
        e = q.pop_front();
        check("response", {re, rd}, e);
      end
    end
  // Entered at a falling edge; waits are bounded so a hang ends the run
  task cmd(input [2:0] o, input [15:0] ad, input [15:0] d, input [15:0] v, input er);
    begin
      q.push_back({er, v});
      op = o;
      ca = ad;
      cd = d;
      cv = 1;
      n = 0;
      while (!rdy && n < 99)
      begin
        @(negedge clk);
        n++;
      end
      @(negedge clk);
      cv = 0;
      while (!rv && n < 9999)
      begin
        @(negedge clk);
        n++;
      end
      if (n >= 9999)
      begin
        error_cnt++;
        close_out;
      end
      @(negedge clk);
    end
  endtask
  // A refused or bit-raising write that leaves stored bit 7 unlike the data bit 7 never passes polling, so polling gives up
  task prog(input [15:0] ad, input [15:0] d);
    begin
      rm[ad] = (lk && ad < 16'h2000) ? rm[ad] : rm[ad] & d;
      cmd(`FLC_OP_PROGRAM, ad, d, rm[ad], rm[ad][7] !== d[7]);
    end
  endtask
  task erase(input [2:0] o);
    begin
      for (i = 0; i < 65536; i++)
        if (i >= 16'h2000 || (o == `FLC_OP_CHIP_ERASE && !lk)) rm[i] = 16'hFFFF;
      cmd(o, 0, 0, 16'hFFFF, 0);
      for (k = 0; k < 2; k++) cmd(`FLC_OP_READ, 16'h1FFF + k, 0, rm[16'h1FFF + k], 0);
    end
  endtask
  task ident;
    begin
      cmd(`FLC_OP_ID_ENTRY, 0, 0, 0, 0);
      check("id_mode", idm, 1);
      for (k = 0; k < 3; k++) cmd(`FLC_OP_READ, k, 0, idv[k], 0);
    end
  endtask
  initial
  begin
    {cv, op, ca, cd, lk} = 0;
    rst_n = 0;
    idv = '{MFR, DEV, 16'h0000};
    for (i = 0; i < 65536; i++) rm[i] = 16'hFFFF;
    void'($urandom(42321));
    repeat (16) @(negedge clk);
    rst_n = 1;
    repeat (2) @(negedge clk);
    for (k = 0; k < 8; k++)
    begin
      a = k < 4 ? 16'h1FFE + k[15:0] : 16'h6000 + 16'($urandom % 1024);
      prog(a, 16'($urandom));
      prog(a, 16'($urandom));
      cmd(`FLC_OP_READ, a, 0, rm[a], 0);
    end
    $display("program test done");
    ident;
    cmd(`FLC_OP_ID_EXIT3, 0, 0, 0, 0);
    check("id_mode", idm, 0);
    erase(`FLC_OP_CHIP_ERASE);
    prog(16'h1FFF, 16'h3C5A);
    prog(16'h2000, 16'h00A5);
    erase(`FLC_OP_MAIN_ERASE);
    $display("erase test done");
    cmd(`FLC_OP_LOCKOUT, 0, 0, rm[16'h5555], 0);
    lk = 1;
    idv[2] = 16'h0001;
    ident;
    cmd(`FLC_OP_ID_EXIT1, 16'($urandom), 0, 0, 0);
    check("id_mode", idm, 0);
    prog(16'h1FFF, 16'h0000);
    prog(16'h2000, 16'h0011);
    erase(`FLC_OP_CHIP_ERASE);
    erase(`FLC_OP_MAIN_ERASE);
    $display("lockout test done");
    close_out;
  end
endmodule
